// ===== core/pcrc_pkg.sv
// Package for the programmable CRC generator: map, fields, types.
// Assumes one 20 MHz clock and a 32-bit AHB-Lite register bus.
package pcrc_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFS_CTRL1  = 8'h00; // Control one
   localparam logic [7:0] OFS_CTRL2  = 8'h04; // Control two
   localparam logic [7:0] OFS_POLYLO = 8'h08; // Poly terms low
   localparam logic [7:0] OFS_POLYHI = 8'h0c; // Poly terms high
   localparam logic [7:0] OFS_DATLO  = 8'h10; // Input data low
   localparam logic [7:0] OFS_DATHI  = 8'h14; // Input data high
   localparam logic [7:0] OFS_RESLO  = 8'h18; // Result shift low
   localparam logic [7:0] OFS_RESHI  = 8'h1c; // Result shift high
   localparam logic [7:0] OFS_STAT   = 8'h20; // Settle status

   // Control one bit positions
   localparam int B_EN   = 15;
   localparam int B_IDL  = 13;
   localparam int B_RUN  = 4;
   localparam int B_ISEL = 5;
   localparam int B_DIR  = 3;

   // Width thresholds and FIFO depths
   localparam logic [4:0] DW_WIDE  = 5'h0f;
   localparam logic [4:0] DW_MID   = 5'h07;
   localparam logic [4:0] DEPTH_4  = 5'h04;
   localparam logic [4:0] DEPTH_8  = 5'h08;
   localparam logic [4:0] DEPTH_16 = 5'h10;

   // Software control bits of control one
   typedef struct packed {
      logic en;
      logic idle_stop;
      logic isel;
      logic run;
      logic shift_direction_bit;
   } pcrc_ctrl_type;

   // Control two fields
   typedef struct packed {
      logic [4:0] data_width_field;
      logic [4:0] poly_length_field;
   } pcrc_cfg_type;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SHIFT  = 3'b010,
      ST_SETTLE = 3'b100
   } pcrc_state_type;

   // Mask of the low w+1 bits
   function automatic logic [31:0] pcrc_mask(input logic [4:0] w);
      pcrc_mask = 32'hffffffff >> (5'h1f - w);
   endfunction : pcrc_mask

endpackage : pcrc_pkg

// ===== core/pcrc_fifo.sv
// Data FIFO of the CRC generator, sixteen words of storage.
// Assumes the caller never pushes when count reaches depth.
module pcrc_fifo
   import pcrc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        clr,
   input  wire logic        push,
   input  wire logic [31:0] wdata,
   input  wire logic        pop,
   output logic [31:0]      rdata,
   output logic [4:0]       count
);
   logic [31:0] mem [16]; // Word storage
   logic [3:0]  wp;       // Write pointer
   logic [3:0]  rp;       // Read pointer

   assign rdata = mem[rp];

   // Storage needs no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= wdata;
      end
   end

   // Pointers wrap at 16; depth only limits count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp    <= 4'h0;
         rp    <= 4'h0;
         count <= 5'h00;
      end else if (clr) begin
         wp    <= 4'h0;
         rp    <= 4'h0;
         count <= 5'h00;
      end else begin
         wp    <= wp + 4'(push);
         rp    <= rp + 4'(pop);
         count <= count + 5'(push) - 5'(pop);
      end
   end
endmodule : pcrc_fifo

// ===== core/pcrc_engine.sv
// CRC shift engine with its word buffer, two bits per clock.
// Assumes load only while busy is low.
module pcrc_engine
   import pcrc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        clr,
   input  wire logic        hold,
   input  wire logic        load,
   input  wire logic [31:0] word,
   input  wire pcrc_cfg_type cfg,
   input  wire logic        shift_direction_bit,
   input  wire logic [31:0] taps,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [15:0] wdat,
   output logic [31:0]      crc,
   output logic             busy
);
   logic [31:0] wbuf;  // Word being shifted
   logic [5:0]  left;  // Bits still to shift
   logic        d0;
   logic        d1;
   logic [31:0] one;
   logic [31:0] two;

   // One engine step: top bit feedback into enabled taps
   function automatic logic [31:0] step(input logic [31:0] c,
      input logic d, input logic [31:0] t, input logic [4:0] p);
      logic fb;
      fb   = d ^ c[p];
      step = ({c[30:0], 1'b0} ^ ({32{fb}} & (t | 32'h1)))
             & pcrc_mask(p);
   endfunction : step

   assign d0   = shift_direction_bit ? wbuf[0] : wbuf[cfg.data_width_field];
   assign d1   = shift_direction_bit ? wbuf[1] : wbuf[cfg.data_width_field - 5'h1];
   assign one  = step(crc, d0, taps, cfg.poly_length_field);
   assign two  = step(one, d1, taps, cfg.poly_length_field);
   assign busy = (left != 6'h00);

   // Buffer load, then two bits a cycle, one if a single bit is left
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crc  <= 32'h0;
         wbuf <= 32'h0;
         left <= 6'h00;
      end else if (clr) begin
         crc  <= 32'h0;
         wbuf <= 32'h0;
         left <= 6'h00;
      end else if (wr_lo || wr_hi) begin
         if (wr_lo) crc[15:0] <= wdat;
         if (wr_hi) crc[31:16] <= wdat;
      end else if (!hold) begin
         if (load) begin
            wbuf <= word;
            left <= {1'b0, cfg.data_width_field} + 6'h01;
         end else if (left >= 6'h02) begin
            crc  <= two;
            wbuf <= shift_direction_bit ? wbuf >> 2 : wbuf << 2;
            left <= left - 6'h02;
         end else if (left == 6'h01) begin
            crc  <= one;
            left <= 6'h00;
         end
      end
   end

   a_two_bits: assert property (@(posedge clk) disable iff (!rstn)
      left >= 6'h02 && !hold && !load && !clr && !wr_lo && !wr_hi
      |=> left == $past(left) - 6'h02)
      else $error("engine did not shift two bits");
endmodule : pcrc_engine

// ===== core/pcrc_top.sv
// Programmable CRC generator: AHB-Lite slave, FIFO feed, sequencer.
// Assumes a single AHB-Lite master, word transfers, hclk at 20 MHz.
//
// Overview of operation
// - x^0 term always fed back
// - Length 32 uses implicit top term
// - Data width one to 32 bits
// - FIFO depth 4, 8 or 16 by width
// - Width field holds width minus one
// - Length field holds length minus one
// - Bits above width are ignored
// - Count rises when MSb half written
// - Shift only with run and data
// - Buffer word, shift two bits per cycle
// - Full at depth, empty at zero
// - Disable empties FIFO and resets state
// - Direction bit picks MSb or LSb first
// - Interrupt on empty or on finish
// - Software run clear gives no interrupt
// - Result settles length/2 cycles later
// - Run clears when calculation completes
// - Idle-stop halts in idle mode
// - Term bits insert or remove XORs
// - Data registers read as zero
// - Result pair loads and reads engine
//
// Added by the designer: the register addresses and register access over AHB-Lite.
module pcrc_top
   import pcrc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        sys_idle,
   output logic             crc_irq
);

   // Software-visible state
   pcrc_ctrl_type  ctrl;      // Control one bits
   pcrc_cfg_type   cfg;       // Width and length
   logic [31:1]    taps;      // Polynomial term enables
   logic [15:0]    stage;     // Low half awaiting its high half

   // Sequencer
   pcrc_state_type state;     // Current state
   pcrc_state_type next_state;
   logic [5:0]     settle;    // Cycles until result is final

   // Bus data-phase capture
   logic           wr_q;      // Write pending in data phase
   logic [7:0]     addr_q;    // Its offset
   logic           addr_ok;   // Upper address bits zero
   logic [2:0]     size_q;    // Kept for completeness of capture

   // Wires between the parts
   logic [31:0]    fifo_head;
   logic [4:0]     count;
   logic [31:0]    crc;
   logic           busy;
   logic           push;
   logic [31:0]    push_word;
   logic           pop;
   logic           hw_done;
   logic           next_run;
   logic           next_irq;
   logic [31:0]    rd_mux;

   // Address phase qualifier
   logic access;
   assign access = hsel && hready && htrans[1];

   // Decode of the captured write offset
   logic we_c1, we_c2, we_plo, we_phi;
   logic we_dlo, we_dhi, we_rlo, we_rhi;
   assign we_c1  = wr_q && addr_ok && (addr_q == OFS_CTRL1);
   assign we_c2  = wr_q && addr_ok && (addr_q == OFS_CTRL2);
   assign we_plo = wr_q && addr_ok && (addr_q == OFS_POLYLO);
   assign we_phi = wr_q && addr_ok && (addr_q == OFS_POLYHI);
   assign we_dlo = wr_q && addr_ok && (addr_q == OFS_DATLO);
   assign we_dhi = wr_q && addr_ok && (addr_q == OFS_DATHI);
   assign we_rlo = wr_q && addr_ok && (addr_q == OFS_RESLO);
   assign we_rhi = wr_q && addr_ok && (addr_q == OFS_RESHI);

   // FIFO depth follows the width field
   logic [4:0] depth;
   assign depth = (cfg.data_width_field > DW_WIDE) ? DEPTH_4 :
                  (cfg.data_width_field > DW_MID)  ? DEPTH_8 : DEPTH_16;

   // Flags derived from the count
   logic full;
   logic empty;
   assign full  = (count == depth);
   assign empty = (count == 5'h00);

   // Wide words need both halves; narrow ones finish in the low half
   logic wide;
   assign wide = (cfg.data_width_field > DW_WIDE);

   // Push when the half holding the MSb lands; dropped when full
   assign push = ctrl.en && !full &&
                 ((we_dlo && !wide) || (we_dhi && wide));
   assign push_word = (wide ? {hwdata[15:0], stage}
                            : {16'h0, hwdata[15:0]})
                      & pcrc_mask(cfg.data_width_field);

   // Idle-stop freezes both feed and shifting
   logic halted;
   assign halted = ctrl.idle_stop && sys_idle;

   // Next word goes to the buffer once the engine is free
   assign pop = (state == ST_SHIFT) && ctrl.run && !empty
                && !busy && !halted;

   // Finished: nothing queued, nothing buffered
   assign hw_done = (state == ST_SHIFT) && ctrl.run && empty
                    && !busy && !halted;

   // Software write of run wins over the hardware clear
   assign next_run = we_c1 ? hwdata[B_RUN] :
                     hw_done ? 1'b0 : ctrl.run;

   // Interrupt cause; a software clear alone never raises it
   assign next_irq = ctrl.isel ? hw_done
                               : (pop && !push && count == 5'h01);

   // Sequencer transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (ctrl.run) next_state = ST_SHIFT;
         end
         ST_SHIFT: begin
            if (hw_done) next_state = ST_SETTLE;
            else if (!ctrl.run) next_state = ST_IDLE; // Software stop
         end
         ST_SETTLE: begin
            if (settle <= 6'h01 && !halted) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Read data chosen in the address phase
   logic [7:0] ra;
   assign ra = haddr[7:0];
   always_comb begin
      rd_mux = 32'h0;
      if (haddr[31:8] != 24'h0) begin
         rd_mux = 32'h0; // Unmapped reads as zero
      end else if (ra == OFS_CTRL1) begin
         rd_mux = {16'h0, ctrl.en, 1'b0, ctrl.idle_stop, count,
                   full, empty, ctrl.isel, ctrl.run, ctrl.shift_direction_bit,
                   3'h0};
      end else if (ra == OFS_CTRL2) begin
         rd_mux = {19'h0, cfg.data_width_field, 3'h0, cfg.poly_length_field};
      end else if (ra == OFS_POLYLO) begin
         rd_mux = {16'h0, taps[15:1], 1'b0};
      end else if (ra == OFS_POLYHI) begin
         rd_mux = {16'h0, taps[31:16]};
      end else if (ra == OFS_RESLO) begin
         rd_mux = {16'h0, crc[15:0]};
      end else if (ra == OFS_RESHI) begin
         rd_mux = {16'h0, crc[31:16]};
      end else if (ra == OFS_STAT) begin
         rd_mux = {31'h0, state == ST_SETTLE};
      end else begin
         rd_mux = 32'h0; // Data pair and holes
      end
   end

   // Bus slave: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0;
         wr_q      <= 1'b0;
         addr_q    <= 8'h00;
         addr_ok   <= 1'b0;
         size_q    <= 3'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_q      <= access && hwrite;
         if (access) begin
            addr_q  <= haddr[7:0];
            addr_ok <= (haddr[31:8] == 24'h0);
            size_q  <= hsize;
         end
         // Registered so the data phase sees a flop
         if (access && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Control one; enable clear keeps these settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= '0;
      end else begin
         if (we_c1) begin
            ctrl.en        <= hwdata[B_EN];
            ctrl.idle_stop <= hwdata[B_IDL];
            ctrl.isel      <= hwdata[B_ISEL];
            ctrl.shift_direction_bit   <= hwdata[B_DIR];
         end
         ctrl.run <= next_run;
      end
   end

   // Control two and polynomial terms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg  <= '0;
         taps <= '0;
      end else begin
         if (we_c2) begin
            cfg.data_width_field <= hwdata[12:8];
            cfg.poly_length_field   <= hwdata[4:0];
         end
         if (we_plo) taps[15:1]  <= hwdata[15:1];
         if (we_phi) taps[31:16] <= hwdata[15:0];
      end
   end

   // Low half staging; cleared with the unit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage <= 16'h0;
      end else if (!ctrl.en) begin
         stage <= 16'h0;
      end else if (we_dlo && wide) begin
         stage <= hwdata[15:0];
      end
   end

   // Sequencer, settle count and interrupt pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state   <= ST_IDLE;
         settle  <= 6'h00;
         crc_irq <= 1'b0;
      end else if (!ctrl.en) begin
         state   <= ST_IDLE;
         settle  <= 6'h00;
         crc_irq <= 1'b0;
      end else begin
         state   <= next_state;
         crc_irq <= next_irq;
         if (hw_done) begin
            settle <= ({1'b0, cfg.poly_length_field} + 6'h01) >> 1;
         end else if (state == ST_SETTLE && !halted
                      && settle != 6'h00) begin
            settle <= settle - 6'h01;
         end
      end
   end

   // Word FIFO; disable empties it
   pcrc_fifo u_fifo (
      .clk   (hclk),
      .rstn  (hresetn),
      .clr   (!ctrl.en),
      .push  (push),
      .wdata (push_word),
      .pop   (pop),
      .rdata (fifo_head),
      .count (count)
   );

   // Shift engine; held while stopped or idle-halted
   pcrc_engine u_engine (
      .clk     (hclk),
      .rstn    (hresetn),
      .clr     (!ctrl.en),
      .hold    (halted || !ctrl.run),
      .load    (pop),
      .word    (fifo_head),
      .cfg     (cfg),
      .shift_direction_bit (ctrl.shift_direction_bit),
      .taps    ({taps, 1'b0}),
      .wr_lo   (we_rlo && ctrl.en),
      .wr_hi   (we_rhi && ctrl.en),
      .wdat    (hwdata[15:0]),
      .crc     (crc),
      .busy    (busy)
   );

   // Checks beside the logic they guard
   a_irq_finish: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hw_done && ctrl.isel && ctrl.en |=> crc_irq)
      else $error("no interrupt on finish");

   a_irq_empty: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ctrl.en && !ctrl.isel && pop && !push && count == 5'h01
      |=> crc_irq && count == 5'h00)
      else $error("no interrupt on FIFO empty");

   a_irq_cause: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !hw_done && !pop |=> !crc_irq)
      else $error("interrupt without a cause");

   a_run_clear: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hw_done && !we_c1 |=> !ctrl.run ##1 !crc_irq || ctrl.isel)
      else $error("run not cleared at finish");

   a_count_limit: assert property (@(posedge hclk)
      disable iff (!hresetn)
      count <= depth || $changed(cfg.data_width_field))
      else $error("FIFO count beyond depth");

   a_disable_clr: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !ctrl.en |=> count == 5'h00 && !busy && stage == 16'h0)
      else $error("disable did not clear state");

   a_pop_gate: assert property (@(posedge hclk)
      disable iff (!hresetn)
      pop |-> ctrl.run && count != 5'h00 && !halted)
      else $error("shift started without run or data");

   a_push_msb: assert property (@(posedge hclk)
      disable iff (!hresetn)
      we_dlo && !wide && ctrl.en && !full && !pop
      |=> count == $past(count) + 5'h01)
      else $error("count did not rise on MSb write");

   a_settle_len: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hw_done && ctrl.en
      |=> settle == ({1'b0, $past(cfg.poly_length_field)} + 6'h01) >> 1)
      else $error("settle count wrong");

endmodule : pcrc_top

// ===== verification/pcrc_top_tb.sv
// Self-checking bench for the programmable CRC generator top.
// Assumes the design drives hreadyout, so the bench feeds it back as hready.
module pcrc_top_tb;
   import pcrc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk;            // 20 MHz bus clock
   logic        hresetn;         // Async reset, active low
   logic        hsel;            // Slave select
   logic [31:0] haddr;           // Bus address
   logic [1:0]  htrans;          // Transfer type
   logic        hwrite;          // Write strobe
   logic [2:0]  hsize;           // Always a word
   logic [31:0] hwdata;          // Write data
   logic        hreadyout;       // Slave ready, also the bus ready
   logic        hresp;           // Response, always OKAY
   logic [31:0] hrdata;          // Read data
   logic        sys_idle;        // System idle mode request
   logic        crc_irq;         // Interrupt pulse
   int          fail_count;      // Mismatches seen
   int          samples_checked; // Comparisons made
   int          irq_count;       // Interrupt pulses seen
   int          cycles;          // Cycles since start
   logic [31:0] rd;              // Scratch read value

   pcrc_top i_dut (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .sys_idle  (sys_idle),
      .crc_irq   (crc_irq)
   );

   // Free-running clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Pulse counter and hang guard
   always @(posedge hclk) begin
      cycles++;
      if (crc_irq === 1'b1) begin
         irq_count++;
      end
      if (cycles == 30000) begin
         fail_count++;
         stop_test();
      end
   end

   // One comparison, counted
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Single word transfer; waits on ready, no fixed latency assumed
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, a, d, dummy);
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h00000000, v);
      chk(what, v, exp);
   endtask : rdc

   // Bench model of the engine, one bit at a time
   function automatic logic [31:0] ref_crc(input logic [31:0] c,
      input logic [31:0] taps, input int poly_length_field, input int dw,
      input logic [31:0] d, input bit lsb);
      logic [31:0] m;
      logic        fb;
      m = (poly_length_field == 31) ? 32'hffffffff : ((32'h1 << (poly_length_field + 1)) - 1);
      for (int i = 0; i <= dw; i++) begin
         fb = (lsb ? d[i] : d[dw - i]) ^ c[poly_length_field];
         c  = (c << 1) ^ (fb ? (taps | 32'h1) : 32'h0);
         c  = c & m;
      end
      return c;
   endfunction : ref_crc

   // Push one word, high half last for wide widths
   task automatic push(input int dw, input logic [31:0] d);
      wr(OFS_DATLO, {16'h0000, d[15:0]});
      if (dw > 15) begin
         wr(OFS_DATHI, {16'h0000, d[31:16]});
      end
   endtask : push

   // Depth, full flag and disable clearing, across width boundaries
   task automatic t_depth(input int dw, input int depth);
      logic [31:0] en;
      en = 32'h1 << B_EN;
      wr(OFS_CTRL1, en);
      wr(OFS_CTRL2, dw << 8);
      for (int i = 0; i <= depth; i++) begin
         push(dw, 32'h5a5a5a5a + i);
      end
      rdc("full_ctrl", OFS_CTRL1, en | (depth << 8) | 32'h80);
      wr(OFS_CTRL1, 32'h0);
      rdc("off_ctrl", OFS_CTRL1, 32'h40);
      rdc("ctrl2_kept", OFS_CTRL2, dw << 8);
   endtask : t_depth

   // Full calculation; idle option also checks a software stop
   task automatic t_crc(input int dw, input int poly_length_field, input logic [31:0] taps,
                        input bit lsb, input bit isel, input bit idle,
                        input logic [31:0] d0, input logic [31:0] d1);
      logic [31:0] ctl;
      logic [31:0] m;
      logic [31:0] exp;
      int          n;
      m   = (dw == 31) ? 32'hffffffff : ((32'h1 << (dw + 1)) - 1);
      exp = ref_crc(32'h0, taps, poly_length_field, dw, d0 & m, lsb);
      exp = ref_crc(exp, taps, poly_length_field, dw, d1 & m, lsb);
      ctl = (32'h1 << B_EN) | (isel << B_ISEL) | (lsb << B_DIR)
            | (idle << B_IDL);
      wr(OFS_CTRL1, ctl);
      wr(OFS_POLYLO, {16'h0000, taps[15:0] | 16'h0001});
      wr(OFS_POLYHI, {16'h0000, taps[31:16]});
      rdc("poly_lo", OFS_POLYLO, {16'h0000, taps[15:1], 1'b0});
      wr(OFS_CTRL2, (dw << 8) | poly_length_field);
      push(dw, d0);
      push(dw, d1);
      rdc("data_lo", OFS_DATLO, 32'h0);
      chk("data_lo_resp", {31'h0, hresp}, 32'h0);
      rdc("vwords", OFS_CTRL1, ctl | 32'h200);
      wr(OFS_RESLO, 32'h0);
      // Idle cycle in every transfer keeps the count read a cycle away
      wr(OFS_RESHI, 32'h0);
      irq_count = 0;
      if (idle) begin
         sys_idle <= 1'b1;
         wr(OFS_CTRL1, ctl | (32'h1 << B_RUN));
         repeat (80) @(posedge hclk);
         rdc("idle_hold", OFS_CTRL1, ctl | 32'h210);
         wr(OFS_CTRL1, ctl);
         sys_idle <= 1'b0;
         repeat (80) @(posedge hclk);
         chk("sw_stop_irq", irq_count, 0);
      end
      wr(OFS_CTRL1, ctl | (32'h1 << B_RUN));
      n = 0;
      do begin
         xfer(1'b0, OFS_CTRL1, 32'h0, rd);
         n++;
      end while (rd[B_RUN] !== 1'b0 && n < 100);
      chk("run_clear", rd, ctl | 32'h40);
      repeat (20) @(posedge hclk);
      chk("irq_count", irq_count, 1);
      rdc("settled", OFS_STAT, 32'h0);
      xfer(1'b0, OFS_RESHI, 32'h0, rd);
      rdc("crc_lo", OFS_RESLO, {16'h0000, exp[15:0]});
      chk("crc_hi", rd, {16'h0000, exp[31:16]});
   endtask : t_crc

   // Verdict and end of run
   task automatic stop_test();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      fail_count = 0;
      samples_checked = 0;
      irq_count = 0;
      cycles = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      sys_idle = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("ctrl1_rst", OFS_CTRL1, 32'h40);
      rdc("ctrl2_rst", OFS_CTRL2, 32'h0);
      rdc("unmapped", 8'h80, 32'h0);
      t_depth(3, 16);
      t_depth(7, 16);
      t_depth(8, 8);
      t_depth(15, 8);
      t_depth(16, 4);
      t_depth(31, 4);
      t_crc(7, 15, 32'h00001021, 1'b0, 1'b1, 1'b0, 32'hff31, 32'hff32);
      t_crc(7, 15, 32'h00001021, 1'b1, 1'b0, 1'b0, 32'h00a5, 32'h003c);
      t_crc(31, 31, 32'h04c11db7, 1'b0, 1'b1, 1'b1,
            32'h12345678, 32'hcafef00d);
      t_crc(4, 7, 32'h00000007, 1'b1, 1'b1, 1'b0, 32'h00f3, 32'h0011);
      stop_test();
   end
endmodule : pcrc_top_tb
